/* File: inc/fep_params.svh */
// Purpose: constants of the fast ethernet coding core
// Assumes: included by bare name
// Notes: definitions only
`ifndef FEP_PARAMS_SVH
`define FEP_PARAMS_SVH
// line code groups, first bit sent is the msb
`define FEP_SYM_IDLE 5'h1F
`define FEP_SYM_J 5'h18
`define FEP_SYM_K 5'h11
`define FEP_SYM_T 5'h0D
`define FEP_SYM_R 5'h07
`define FEP_SYM_H 5'h04
// data groups for nibbles F down to 0, five bits each
`define FEP_ENC_TAB 80'hEF37ABDA727B96AAD13E
`define FEP_PRE_NIB 4'h5
// scrambler seed and idle lock length in matching bits
`define FEP_SCR_SEED 11'h7FF
`define FEP_LOCK_CNT 6'h1E
// bits without a line transition before activity drops
`define FEP_QUIET_BITS 7'h40
// strap pin positions
`define FEP_STRAP_DUP 0
`define FEP_STRAP_ANEG 1
`define FEP_STRAP_BCO 2
`define FEP_STRAP_TEST_B 3
// basic control image
`define FEP_CTRL_RST 16'h0000
`define FEP_CTRL_DUP_BIT 8
`define FEP_CTRL_ANEG_BIT 12
`define FEP_BCAST_ADDR 5'h00
// data path fifo
`define FEP_FIFO_DEPTH 4
`define FEP_TXW_W 5
`define FEP_RXW_W 6
`endif

/* File: inc/fep_pkg.sv */
// Purpose: types of the fast ethernet coding core
// Assumes: nothing
// Notes: constants live in fep_params.svh
package fep_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fep_tx_st_t;
    typedef enum logic [1:0] {RX_HUNT, RX_K, RX_DATA} fep_rx_st_t;
endpackage : fep_pkg

/* File: design/fep_fifo.sv */
// Purpose: two clock fifo between nibble side and line side
// Assumes: DEPTH is a power of two
// Notes: gray pointers cross through two flops each
`timescale 1ns/1ns
module fep_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    input wire logic wr_clk, // filling clock
    input wire logic wr_rst_b, // filling reset
    input wire logic wr_valid, // word offered
    output logic wr_ready, // room for a word
    input wire logic [WIDTH-1:0] wr_data, // word in
    input wire logic rd_clk, // draining clock
    input wire logic rd_rst_b, // draining reset
    output logic rd_valid, // word available
    input wire logic rd_ready, // drain takes word
    output logic [WIDTH-1:0] rd_data // word out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wbin_reg, rbin_reg, wgray_reg, rgray_reg;
    logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
    logic [AW:0] wbin_next, rbin_next;

    ////////////////////////////////////////////////////////////////
    // write side
    assign wr_ready = wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
    assign wbin_next = wbin_reg + (AW+1)'(wr_valid && wr_ready);
    always_ff @(posedge wr_clk or negedge wr_rst_b) begin
        if (!wr_rst_b) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= wbin_next ^ (wbin_next >> 1);
        end
    end
    // storage, no reset needed
    always_ff @(posedge wr_clk) begin
        if (wr_valid && wr_ready) mem_reg[wbin_reg[AW-1:0]] <= wr_data;
    end
    // read pointer into write domain
    always_ff @(posedge wr_clk or negedge wr_rst_b) begin
        if (!wr_rst_b) begin
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
        end else begin
            rg_s1_reg <= rgray_reg;
            rg_s2_reg <= rg_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read side
    assign rd_valid = rgray_reg != wg_s2_reg;
    assign rd_data = mem_reg[rbin_reg[AW-1:0]];
    assign rbin_next = rbin_reg + (AW+1)'(rd_valid && rd_ready);
    always_ff @(posedge rd_clk or negedge rd_rst_b) begin
        if (!rd_rst_b) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
        end else begin
            rbin_reg <= rbin_next;
            rgray_reg <= rbin_next ^ (rbin_next >> 1);
            wg_s1_reg <= wgray_reg;
            wg_s2_reg <= wg_s1_reg;
        end
    end

    // a full fifo never accepts
    fifo_full_a: assert property (@(posedge wr_clk) disable iff (!wr_rst_b)
        (wbin_reg - rbin_reg) == (AW+1)'(DEPTH) |-> !wr_ready)
        else $error("fifo accepts while full");
endmodule : fep_fifo

/* File: design/fep_pcs.sv */
// Purpose: strap capture and 100 Mb/s line coding core
// Assumes: line_clk is the 125 MHz recovered bit clock
// Notes: nibble side on sys_clk, line side on line_clk
`timescale 1ns/1ns
`include "fep_params.svh"
module fep_pcs import fep_pkg::*; (
    input wire logic sys_clk, // 100 MHz core clock
    input wire logic rst_b, // async reset
    input wire logic line_clk, // recovered bit clock
    input wire logic [3:0] strap_pin_in, // strap pin level
    output logic [3:0] strap_pin_out, // strap pin drive
    output logic [3:0] strap_pin_oe, // strap pin enable
    output logic [15:0] ctrl_image, // basic control bits
    input wire logic sw_aneg_wr, // software writes bit 12
    input wire logic sw_aneg_val, // value for bit 12
    input wire logic [4:0] phy_addr, // own address
    input wire logic [4:0] mgmt_addr, // address in frame
    output logic mgmt_addr_hit, // frame is for us
    output logic pin_test_mode, // board test mode
    input wire logic mii_tx_en, // transmit enable
    input wire logic [3:0] mii_txd, // transmit nibble
    output logic mii_tx_ready, // nibble accepted
    output logic [3:0] mii_rxd, // receive nibble
    output logic mii_rx_dv, // receive data valid
    output logic mii_rx_er, // receive error
    output logic mii_rx_stb, // new nibble pulse
    input wire logic mac_rx_ready, // mac takes nibble
    output logic tx_mlt3_pos, // line level +1
    output logic tx_mlt3_neg, // line level -1
    input wire logic rx_mlt3_pos, // sliced level +1
    input wire logic rx_mlt3_neg, // sliced level -1
    output logic rx_locked, // descrambler locked
    output logic rx_activity // line transitions seen
);
    localparam logic [79:0] ENC_TAB = `FEP_ENC_TAB;

    // group lookup, error flag in the msb of decode
    function automatic logic [4:0] fep_dec(input logic [4:0] s);
        logic [4:0] r;
        r = {1'b1, 4'h0};
        for (int i = 0; i < 16; i++) begin
            if (ENC_TAB[i*5 +: 5] == s) r = {1'b0, 4'(i)};
        end
        return r;
    endfunction : fep_dec

    ////////////////////////////////////////////////////////////////
    // straps
    logic [3:0] strap_s1, strap_s2, strap_reg;
    logic strap_done_reg, aneg_reg;

    // pin synchroniser, runs through reset
    always_ff @(posedge sys_clk) begin
        strap_s1 <= strap_pin_in;
        strap_s2 <= strap_s1;
    end
    // capture once at the first edge after release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_reg <= 1'b0;
            strap_reg <= 4'h0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_reg <= strap_s2;
        end
    end
    // autoneg enable, strap first then software
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) aneg_reg <= 1'b0;
        else if (!strap_done_reg) aneg_reg <= strap_s2[`FEP_STRAP_ANEG];
        else if (sw_aneg_wr) aneg_reg <= sw_aneg_val;
    end
    // control image, test mode and address match
    always_comb begin
        ctrl_image = `FEP_CTRL_RST;
        ctrl_image[`FEP_CTRL_DUP_BIT] = strap_reg[`FEP_STRAP_DUP];
        ctrl_image[`FEP_CTRL_ANEG_BIT] = aneg_reg;
    end
    assign pin_test_mode = strap_done_reg && !strap_reg[`FEP_STRAP_TEST_B];
    assign mgmt_addr_hit = (mgmt_addr == phy_addr) || ((mgmt_addr == `FEP_BCAST_ADDR) &&
        !strap_reg[`FEP_STRAP_BCO]);
    // pins turn to outputs after capture, sharing receive data
    assign strap_pin_oe = {4{strap_done_reg}};
    assign strap_pin_out = mii_rxd;

    strap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strap_done_reg && $past(strap_done_reg) |-> $stable(strap_reg))
        else $error("strap value changed after capture");
    strap_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(strap_done_reg) |-> strap_pin_oe == 4'hF && $past(strap_pin_oe) == 4'h0)
        else $error("strap pins not turned to outputs");
    dup_bit_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(strap_done_reg) |-> ctrl_image[8] == $past(strap_s2[0]))
        else $error("duplex bit not loaded from strap");
    bcast_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strap_done_reg && mgmt_addr == 5'h00 && phy_addr != 5'h00 |->
        mgmt_addr_hit == !strap_reg[2])
        else $error("address zero broadcast wrong");
    aneg_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        strap_done_reg && sw_aneg_wr |=> ctrl_image[12] == $past(sw_aneg_val))
        else $error("software autoneg write lost");
    test_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(strap_done_reg) |-> pin_test_mode == !$past(strap_s2[3]))
        else $error("test mode not from strap");

    ////////////////////////////////////////////////////////////////
    // line domain reset, async assert, synced release
    logic lrst_s1, lnk_rst_b;
    always_ff @(posedge line_clk or negedge rst_b) begin
        if (!rst_b) begin
            lrst_s1 <= 1'b0;
            lnk_rst_b <= 1'b0;
        end else begin
            lrst_s1 <= 1'b1;
            lnk_rst_b <= lrst_s1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // transmit, nibble side
    logic tx_en_d_reg, tx_end_pend_reg, tx_wr_ready;
    logic tx_rd_valid, tx_rd_ready;
    logic [`FEP_TXW_W-1:0] tx_rd_data;

    // end marker pending once enable drops
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_en_d_reg <= 1'b0;
            tx_end_pend_reg <= 1'b0;
        end else begin
            tx_en_d_reg <= mii_tx_en;
            tx_end_pend_reg <= (tx_en_d_reg && !mii_tx_en) || (tx_end_pend_reg && !tx_wr_ready);
        end
    end
    assign mii_tx_ready = tx_wr_ready && !tx_end_pend_reg;

    fep_fifo #(.WIDTH(`FEP_TXW_W), .DEPTH(`FEP_FIFO_DEPTH)) u_tx_fifo (
        .wr_clk(sys_clk),
        .wr_rst_b(rst_b),
        .wr_valid(mii_tx_en || tx_end_pend_reg),
        .wr_ready(tx_wr_ready),
        .wr_data(tx_end_pend_reg ? {1'b1, 4'h0} : {1'b0, mii_txd}),
        .rd_clk(line_clk),
        .rd_rst_b(lnk_rst_b),
        .rd_valid(tx_rd_valid),
        .rd_ready(tx_rd_ready),
        .rd_data(tx_rd_data)
    );

    ////////////////////////////////////////////////////////////////
    // transmit, line side
    fep_tx_st_t tx_st_reg, tx_st_next;
    logic [2:0] tx_bit_reg;
    logic [4:0] tx_sh_reg, tx_sym_next;
    logic [10:0] scr_reg;
    logic scr_key, tx_sbit, tx_nrzi_reg, tx_nrzi_d_reg;
    logic [1:0] mlt_idx_reg;
    logic tx_load;

    assign tx_load = tx_bit_reg == 3'h4;
    // next group to send and whether a word is taken
    always_comb begin
        tx_st_next = tx_st_reg;
        tx_sym_next = `FEP_SYM_IDLE;
        tx_rd_ready = 1'b0;
        case (tx_st_reg)
            TX_IDLE: begin
                tx_rd_ready = tx_load && tx_rd_valid;
                if (tx_rd_valid && !tx_rd_data[4]) begin
                    tx_sym_next = `FEP_SYM_J;
                    tx_st_next = TX_K;
                end
            end
            TX_K: begin
                tx_sym_next = `FEP_SYM_K;
                tx_rd_ready = tx_load && tx_rd_valid && !tx_rd_data[4];
                tx_st_next = TX_DATA;
            end
            TX_DATA: begin
                tx_rd_ready = tx_load && tx_rd_valid;
                if (!tx_rd_valid) begin
                    tx_sym_next = `FEP_SYM_H; // underrun
                end else if (tx_rd_data[4]) begin
                    tx_sym_next = `FEP_SYM_T;
                    tx_st_next = TX_R;
                end else begin
                    tx_sym_next = ENC_TAB[tx_rd_data[3:0]*5 +: 5];
                end
            end
            default: begin
                tx_sym_next = `FEP_SYM_R;
                tx_st_next = TX_IDLE;
            end
        endcase
    end
    // group serialiser, one bit per line clock
    always_ff @(posedge line_clk or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            tx_st_reg <= TX_IDLE;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= `FEP_SYM_IDLE;
        end else if (tx_load) begin
            tx_st_reg <= tx_st_next;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= tx_sym_next;
        end else begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
            tx_sh_reg <= {tx_sh_reg[3:0], 1'b0};
        end
    end
    // scrambler on the coded bits
    assign scr_key = scr_reg[10] ^ scr_reg[8];
    assign tx_sbit = tx_sh_reg[4] ^ scr_key;
    always_ff @(posedge line_clk or negedge lnk_rst_b) begin
        if (!lnk_rst_b) scr_reg <= `FEP_SCR_SEED;
        else scr_reg <= {scr_reg[9:0], scr_key};
    end
    // nrzi toggle, mlt3 steps 0,+1,0,-1 on each nrzi edge
    always_ff @(posedge line_clk or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            tx_nrzi_reg <= 1'b0;
            tx_nrzi_d_reg <= 1'b0;
            mlt_idx_reg <= 2'h0;
            tx_mlt3_pos <= 1'b0;
            tx_mlt3_neg <= 1'b0;
        end else begin
            tx_nrzi_reg <= tx_nrzi_reg ^ tx_sbit;
            tx_nrzi_d_reg <= tx_nrzi_reg;
            mlt_idx_reg <= mlt_idx_reg + {1'b0, tx_nrzi_reg ^ tx_nrzi_d_reg};
            tx_mlt3_pos <= mlt_idx_reg == 2'h1;
            tx_mlt3_neg <= mlt_idx_reg == 2'h3;
        end
    end

    sequence s_tx_term;
        tx_load && tx_st_reg == TX_DATA && tx_sym_next == `FEP_SYM_T;
    endsequence
    sequence s_tx_rest;
        tx_load && tx_sym_next == `FEP_SYM_R;
    endsequence
    tx_term_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        s_tx_term |-> ##5 s_tx_rest)
        else $error("end group not followed by reset group");
    tx_ser_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        tx_load |=> tx_bit_reg == 3'h0 ##4 tx_load)
        else $error("group not five bits long");
    tx_nrzi_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        tx_sbit |=> tx_nrzi_reg != $past(tx_nrzi_reg) ##1 mlt_idx_reg != $past(mlt_idx_reg))
        else $error("one bit did not step the line level");
    scr_live_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        scr_reg != 11'h000)
        else $error("scrambler stuck at zero");

    ////////////////////////////////////////////////////////////////
    // receive, line side
    logic [1:0] rxp_s1, rxp_s2;
    logic rx_nrzi_d_reg, rx_nrz, rx_act_reg;
    logic [6:0] quiet_reg;
    logic [10:0] dsc_reg;
    logic dsc_pred, rx_lock_reg, rx_plain;
    logic [5:0] match_reg;
    fep_rx_st_t rx_st_reg;
    logic [3:0] rx_sh_reg;
    logic [4:0] rx_sym, rx_dec;
    logic [2:0] rx_cnt_reg;
    logic rx_ovf_reg, rx_wr_valid, rx_wr_ready;
    logic [`FEP_RXW_W-1:0] rx_wr_data;
    logic rx_rd_valid;
    logic [`FEP_RXW_W-1:0] rx_rd_data;

    // sliced levels through two flops
    always_ff @(posedge line_clk) begin
        rxp_s1 <= {rx_mlt3_pos, rx_mlt3_neg};
        rxp_s2 <= rxp_s1;
    end
    // any nonzero level is nrzi high, an nrzi edge is a one
    assign rx_nrz = (|rxp_s2) ^ rx_nrzi_d_reg;
    always_ff @(posedge line_clk or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            rx_nrzi_d_reg <= 1'b0;
            quiet_reg <= 7'h00;
            rx_act_reg <= 1'b0;
        end else begin
            rx_nrzi_d_reg <= |rxp_s2;
            quiet_reg <= rx_nrz ? 7'h00 : (quiet_reg == `FEP_QUIET_BITS ? quiet_reg : quiet_reg + 7'h01);
            rx_act_reg <= quiet_reg != `FEP_QUIET_BITS;
        end
    end
    // descrambler trains on idle ones, then runs free
    assign dsc_pred = dsc_reg[10] ^ dsc_reg[8];
    assign rx_plain = rx_nrz ^ dsc_pred;
    always_ff @(posedge line_clk or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            dsc_reg <= 11'h000;
            match_reg <= 6'h00;
            rx_lock_reg <= 1'b0;
        end else if (!rx_lock_reg) begin
            dsc_reg <= {dsc_reg[9:0], ~rx_nrz};
            match_reg <= rx_plain ? match_reg + 6'h01 : 6'h00;
            rx_lock_reg <= rx_plain && match_reg == `FEP_LOCK_CNT - 6'h01;
        end else begin
            dsc_reg <= {dsc_reg[9:0], dsc_pred};
            rx_lock_reg <= rx_act_reg; // lost with the line
        end
    end
    // group framing and decode after the descrambler
    assign rx_sym = {rx_sh_reg, rx_plain};
    assign rx_dec = fep_dec(rx_sym);
    always_comb begin
        rx_wr_valid = 1'b0;
        rx_wr_data = {2'b00, `FEP_PRE_NIB};
        if (rx_st_reg == RX_HUNT) begin
            rx_wr_valid = rx_lock_reg && rx_sym == `FEP_SYM_J;
        end else if (rx_cnt_reg == 3'h4) begin
            rx_wr_valid = 1'b1;
            if (rx_st_reg == RX_K) rx_wr_data = rx_sym == `FEP_SYM_K ? rx_wr_data : {2'b11, 4'h0};
            else if (rx_sym == `FEP_SYM_T) rx_wr_data = {1'b1, rx_ovf_reg, 4'h0};
            else if (rx_sym == `FEP_SYM_IDLE) rx_wr_data = {2'b11, 4'h0};
            else rx_wr_data = {1'b0, rx_dec[4] | rx_ovf_reg, rx_dec[3:0]};
        end
    end
    always_ff @(posedge line_clk or negedge lnk_rst_b) begin
        if (!lnk_rst_b) begin
            rx_st_reg <= RX_HUNT;
            rx_sh_reg <= 4'h0;
            rx_cnt_reg <= 3'h0;
            rx_ovf_reg <= 1'b0;
        end else begin
            rx_sh_reg <= rx_sym[3:0];
            rx_cnt_reg <= (rx_wr_valid || rx_st_reg == RX_HUNT) ? 3'h0 : rx_cnt_reg + 3'h1;
            if (rx_wr_valid && rx_st_reg == RX_HUNT) rx_st_reg <= RX_K;
            else if (rx_wr_valid && (rx_wr_data[5] || !rx_lock_reg)) rx_st_reg <= RX_HUNT;
            else if (rx_wr_valid) rx_st_reg <= RX_DATA;
            // a lost word marks the frame, set wins over clear
            rx_ovf_reg <= (rx_wr_valid && !rx_wr_ready) || (rx_ovf_reg && !(rx_wr_valid && rx_wr_data[5]));
        end
    end

    fep_fifo #(.WIDTH(`FEP_RXW_W), .DEPTH(`FEP_FIFO_DEPTH)) u_rx_fifo (
        .wr_clk(line_clk),
        .wr_rst_b(lnk_rst_b),
        .wr_valid(rx_wr_valid),
        .wr_ready(rx_wr_ready),
        .wr_data(rx_wr_data),
        .rd_clk(sys_clk),
        .rd_rst_b(rst_b),
        .rd_valid(rx_rd_valid),
        .rd_ready(mac_rx_ready),
        .rd_data(rx_rd_data)
    );

    sequence s_lock_gain;
        !rx_lock_reg ##1 rx_lock_reg;
    endsequence
    rx_lock_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        s_lock_gain |-> $past(match_reg) == `FEP_LOCK_CNT - 6'h01)
        else $error("lock without enough idle bits");
    rx_release_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        rx_wr_valid && rx_st_reg == RX_HUNT |-> rx_lock_reg)
        else $error("data released before lock");
    rx_nrz_a: assert property (@(posedge line_clk) disable iff (!lnk_rst_b)
        ##1 rx_nrz == ((|rxp_s2) != $past(|rxp_s2)))
        else $error("nrz bit not an nrzi edge");

    ////////////////////////////////////////////////////////////////
    // receive, nibble side
    logic [1:0] lk_s1, lk_s2;

    // one nibble per taken word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mii_rxd <= 4'h0;
            mii_rx_dv <= 1'b0;
            mii_rx_er <= 1'b0;
            mii_rx_stb <= 1'b0;
        end else begin
            mii_rx_stb <= rx_rd_valid && mac_rx_ready;
            if (rx_rd_valid && mac_rx_ready) begin
                mii_rxd <= rx_rd_data[5] ? 4'h0 : rx_rd_data[3:0];
                mii_rx_dv <= !rx_rd_data[5];
                mii_rx_er <= rx_rd_data[4];
            end
        end
    end
    // line status into the core clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            lk_s1 <= 2'b00;
            lk_s2 <= 2'b00;
        end else begin
            lk_s1 <= {rx_lock_reg, rx_act_reg};
            lk_s2 <= lk_s1;
        end
    end
    assign rx_locked = lk_s2[1];
    assign rx_activity = lk_s2[0];
endmodule : fep_pcs

/* File: bench/fep_mac_model.sv */
// Purpose: mac model on the nibble side
// Assumes: sys_clk is the nibble clock
// Notes: received words queue up as {er, dv, rxd}
`timescale 1ns/1ns
module fep_mac_model (
    input wire logic sys_clk, // core clock
    input wire logic stall, // hold off draining
    input wire logic mii_tx_ready, // nibble accepted
    input wire logic [3:0] mii_rxd, // receive nibble
    input wire logic mii_rx_dv, // receive valid
    input wire logic mii_rx_er, // receive error
    input wire logic mii_rx_stb, // new nibble pulse
    output logic mii_tx_en, // transmit enable
    output logic [3:0] mii_txd, // transmit nibble
    output logic mac_rx_ready // drains receive fifo
);
    logic [5:0] rxq [$];
    initial begin
        mii_tx_en = 1'b0;
        mii_txd = 4'h0;
        mac_rx_ready = 1'b0;
    end
    // drain gated by stall, collect every word
    always @(posedge sys_clk) begin
        mac_rx_ready <= ~stall;
        if (mii_rx_stb === 1'b1) rxq.push_back({mii_rx_er, mii_rx_dv, mii_rxd});
    end
    // enable framed around the nibbles, each held until taken
    task automatic send(input logic [3:0] nib [8], output logic late);
        late = 1'b0;
        for (int i = 0; i < 8 && !late; i++) begin
            mii_tx_en <= 1'b1;
            mii_txd <= nib[i];
            late = 1'b1;
            // bounded wait, late stays set if never taken
            for (int w = 0; w < 1000 && late; w++) begin
                @(posedge sys_clk);
                late = mii_tx_ready !== 1'b1;
            end
        end
        mii_tx_en <= 1'b0;
        mii_txd <= 4'h0;
    endtask : send
endmodule : fep_mac_model

/* File: bench/tb_top.sv */
// Purpose: strap capture and looped line traffic
// Assumes: line output looped straight to line input
// Notes: second reset recaptures other straps
`timescale 1ns/1ns
`include "fep_params.svh"
module tb_top;
    logic sys_clk, line_clk, rst_b, sw_aneg_wr, sw_aneg_val, stall;
    logic [3:0] strap_pin_in, strap_pin_out, strap_pin_oe, mii_txd, mii_rxd;
    logic [15:0] ctrl_image;
    logic [4:0] mgmt_addr;
    logic mgmt_addr_hit, pin_test_mode, mii_tx_en, mii_tx_ready, mii_rx_dv, mii_rx_er, mii_rx_stb;
    logic mac_rx_ready, tx_mlt3_pos, tx_mlt3_neg, rx_locked, rx_activity, tx_late;
    logic [3:0] frame [8] = '{4'h5, 4'h5, 4'h5, 4'hD, 4'h0, 4'hF, 4'hA, 4'h6};
    int errors = 0;
    int n_checks = 0;
    int k;
    fep_pcs u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .line_clk(line_clk), .strap_pin_in(strap_pin_in),
        .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe), .ctrl_image(ctrl_image),
        .sw_aneg_wr(sw_aneg_wr), .sw_aneg_val(sw_aneg_val), .phy_addr(5'h03), .mgmt_addr(mgmt_addr),
        .mgmt_addr_hit(mgmt_addr_hit), .pin_test_mode(pin_test_mode), .mii_tx_en(mii_tx_en),
        .mii_txd(mii_txd), .mii_tx_ready(mii_tx_ready), .mii_rxd(mii_rxd), .mii_rx_dv(mii_rx_dv),
        .mii_rx_er(mii_rx_er), .mii_rx_stb(mii_rx_stb), .mac_rx_ready(mac_rx_ready),
        .tx_mlt3_pos(tx_mlt3_pos), .tx_mlt3_neg(tx_mlt3_neg), .rx_mlt3_pos(tx_mlt3_pos),
        .rx_mlt3_neg(tx_mlt3_neg), .rx_locked(rx_locked), .rx_activity(rx_activity));
    fep_mac_model u_mac (.sys_clk(sys_clk), .stall(stall), .mii_tx_ready(mii_tx_ready), .mii_rxd(mii_rxd),
        .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rx_stb(mii_rx_stb), .mii_tx_en(mii_tx_en),
        .mii_txd(mii_txd), .mac_rx_ready(mac_rx_ready));
    ////////////////////////////////////////////////////////////////
    // clocks, line clock unrelated in phase
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        line_clk = 1'b0;
        #17;
        forever #32 line_clk = ~line_clk;
    end
    // compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic finish_test();
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst_b = 1'b0;
        sw_aneg_wr = 1'b0;
        sw_aneg_val = 1'b0;
        stall = 1'b0;
        mgmt_addr = 5'h00;
        strap_pin_in = 4'h5;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("ctrl", ctrl_image, 16'h0100);
        chk("oe", {12'h000, strap_pin_oe}, 16'h000F);
        chk("test", {15'h0, pin_test_mode}, 16'h0001);
        strap_pin_in <= 4'hA;
        repeat (3) @(posedge sys_clk);
        chk("held", ctrl_image, 16'h0100);
        chk("hit0", {15'h0, mgmt_addr_hit}, 16'h0000);
        mgmt_addr <= 5'h03;
        repeat (2) @(posedge sys_clk);
        chk("hit3", {15'h0, mgmt_addr_hit}, 16'h0001);
        for (k = 0; k < 3000 && rx_locked !== 1'b1; k++) @(posedge sys_clk);
        chk("lock", {15'h0, rx_locked}, 16'h0001);
        chk("act", {15'h0, rx_activity}, 16'h0001);
        u_mac.rxq.delete();
        stall <= 1'b1;
        fork
            u_mac.send(frame, tx_late);
            begin
                repeat (100) @(posedge sys_clk);
                stall <= 1'b0;
            end
        join
        chk("tx_wait", {15'h0, tx_late}, 16'h0000);
        for (k = 0; k < 5000 && u_mac.rxq.size() < 9; k++) @(posedge sys_clk);
        chk("count", 16'(u_mac.rxq.size()), 16'h0009);
        for (k = 0; k < 8 && u_mac.rxq.size() > 0; k++) begin
            chk("nib", {10'h0, u_mac.rxq.pop_front()}, {12'h001, frame[k]});
        end
        if (u_mac.rxq.size() > 0) chk("end", {10'h0, u_mac.rxq.pop_front()}, 16'h0000);
        chk("spout", {12'h000, strap_pin_out}, 16'h0000);
        rst_b <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk("oe_rst", {12'h000, strap_pin_oe}, 16'h0000);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("ctrl2", ctrl_image, 16'h1000);
        chk("test2", {15'h0, pin_test_mode}, 16'h0000);
        mgmt_addr <= 5'h00;
        sw_aneg_wr <= 1'b1;
        @(posedge sys_clk);
        sw_aneg_wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("bcast", {15'h0, mgmt_addr_hit}, 16'h0001);
        chk("swaneg", ctrl_image, 16'h0000);
        finish_test();
    end
endmodule : tb_top
